// ---- rtl/opo_pkg.sv ----
// Package: register map, field layout and constants of the phase offset register slice
//
// What this block does
// RULE_01: Software writes zeros into bits 7 to 4 of the offset control register.
// RULE_02: Offset enable bit 3 high applies the programmed phase shift to outputs.
// RULE_03: Offset control bits 2 to 0 form offset word bits 10 down to 8.
// RULE_04: The second delay register forms offset word bits 7 down to 0.
// RULE_05: Each offset word unit shifts derived clocks by one 60 ns step.
// RULE_06: Read-only eight-bit revision register returns the revision; writes do nothing.
// RULE_07: With enable low the stored word is ignored and no shift applies.
package opo_pkg;

    // ****************************************
    // Register map
    // ****************************************
    // Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [3:0] OPO_IDX_CONTROL = 4'h6;
    localparam logic [3:0] OPO_IDX_COUNT_LOW = 4'h7;
    localparam logic [3:0] OPO_IDX_REVISION = 4'hF;
    localparam int OPO_ADDR_W = 12;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int OPO_ENABLE_BIT = 3;
    localparam int OPO_HIGH_MSB = 2;
    localparam int OPO_RSV_LSB = 4;
    localparam int OPO_WORD_W = 11;
    localparam logic [7:0] OPO_CONTROL_RESET = 8'h00;
    localparam logic [7:0] OPO_COUNT_LOW_RESET = 8'h00;
    // Arbitrary neutral revision value
    localparam logic [7:0] OPO_REVISION_DEFAULT = 8'h01;

    // ****************************************
    // Step timing
    // ****************************************
    localparam int OPO_STEP_NS = 60;
    localparam int OPO_CLK_PERIOD_NS = 4;
    localparam int OPO_STEP_CYCLES = OPO_STEP_NS / OPO_CLK_PERIOD_NS;

    // Phase offset handed to the clock generator
    typedef struct packed {
        logic enable;
        logic [10:0] count;
    } opo_offset_type;

    // Converts an index to its APB byte address
    function automatic logic [11:0] opo_byte_addr(input logic [3:0] idx);
        opo_byte_addr = {6'h00, idx, 2'h0};
    endfunction

endpackage

// ---- rtl/opo_regs.sv ----
// Module: APB register slice holding the output phase offset and revision word
`timescale 1ns/10ps
module opo_regs import opo_pkg::*; #(
    parameter logic [7:0] REVISION = OPO_REVISION_DEFAULT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Offset to the output clock generator
    output opo_offset_type applied_offset,
    output logic [15:0] applied_shift_cycles
);

    // ****************************************
    // Address decode
    // ****************************************
    logic [7:0] control_ff;
    logic [7:0] count_low_ff;
    logic [31:0] nxt_prdata;
    logic [7:0] nxt_control;
    logic [7:0] nxt_count_low;
    opo_offset_type nxt_offset;
    logic [15:0] nxt_shift;

    wire access = psel && penable;
    wire wr = access && pwrite && pstrb[0];
    wire hit_control = paddr == opo_byte_addr(OPO_IDX_CONTROL);
    wire hit_low = paddr == opo_byte_addr(OPO_IDX_COUNT_LOW);
    wire hit_rev = paddr == opo_byte_addr(OPO_IDX_REVISION);
    wire mapped = hit_control || hit_low || hit_rev;
    wire [10:0] word = {control_ff[OPO_HIGH_MSB:0], count_low_ff}; // RULE_03 RULE_04
    wire enable = control_ff[OPO_ENABLE_BIT];

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Reserved bits forced to zero so a careless write cannot reach them
    assign nxt_control = (wr && hit_control) ?
        {4'h0, pwdata[OPO_RSV_LSB-1:0]} : control_ff; // RULE_01
    assign nxt_count_low = (wr && hit_low) ? pwdata[7:0] : count_low_ff;
    // Revision has no storage, so writes to it fall away
    // Read data is captured in the setup cycle so it already stands in the access cycle
    assign nxt_prdata = !(psel && !penable && !pwrite) ? prdata :
        hit_control ? {24'h0, control_ff} :
        hit_low ? {24'h0, count_low_ff} :
        hit_rev ? {24'h0, REVISION} : // RULE_06
        32'h0;

    // Disabled offset drives a zero word so no shift is applied
    assign nxt_offset.enable = enable; // RULE_02
    assign nxt_offset.count = enable ? word : 11'h000; // RULE_07
    // One unit equals one 60 ns step of pclk cycles
    assign nxt_shift = enable ? 16'(word) * 16'(OPO_STEP_CYCLES) : 16'h0000; // RULE_05

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_ff <= OPO_CONTROL_RESET;
            count_low_ff <= OPO_COUNT_LOW_RESET;
            prdata <= 32'h0000_0000;
            applied_offset <= '0;
            applied_shift_cycles <= 16'h0000;
        end else begin
            control_ff <= nxt_control;
            count_low_ff <= nxt_count_low;
            prdata <= nxt_prdata;
            applied_offset <= nxt_offset;
            applied_shift_cycles <= nxt_shift;
        end
    end

    // ****************************************
    // Checks: building blocks
    // ****************************************
    // Steps of a bus transfer, shared by the properties below
    sequence ctrl_write_s;
        wr && hit_control;
    endsequence

    sequence low_write_s;
        wr && hit_low;
    endsequence

    sequence rev_write_s;
        wr && hit_rev;
    endsequence

    // Setup cycles of reads, one per register
    sequence ctrl_read_s;
        psel && !penable && !pwrite && hit_control;
    endsequence

    sequence low_read_s;
        psel && !penable && !pwrite && hit_low;
    endsequence

    sequence rev_read_s;
        psel && !penable && !pwrite && hit_rev;
    endsequence

    // Access phase that follows a setup cycle
    sequence access_s;
        psel && penable;
    endsequence

    // ****************************************
    // Checks: register storage
    // ****************************************
    // Reserved bits never hold a one, whatever software writes
    AST_RSV_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        control_ff[7:4] == 4'h0)
        else $error("Reserved control bits not zero");

    AST_CTRL_STORE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        ctrl_write_s |=> control_ff == {4'h0, $past(pwdata[3:0])})
        else $error("Control write not stored");

    AST_LOW: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        low_write_s |=> count_low_ff == $past(pwdata[7:0]))
        else $error("Low offset bits wrong");

    // Only the low byte lane carries data, so a write without it must do nothing
    AST_NO_STROBE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        access && pwrite && !pstrb[0] |=> $stable(control_ff) && $stable(count_low_ff))
        else $error("Write without byte lane changed a register");

    // The revision word has no storage behind it
    AST_REV_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        rev_write_s |=> $stable(control_ff) && $stable(count_low_ff))
        else $error("Revision write changed a register");

    AST_UNMAPPED_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && !mapped |=> $stable(control_ff) && $stable(count_low_ff))
        else $error("Unmapped write changed a register");

    // ****************************************
    // Checks: bus answers
    // ****************************************
    AST_REVISION: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        rev_read_s ##1 access_s |-> prdata == {24'h0, REVISION})
        else $error("Revision read wrong");

    AST_CTRL_READ: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        ctrl_read_s ##1 access_s |-> prdata == {24'h0, $past(control_ff)})
        else $error("Control read wrong");

    AST_LOW_READ: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        low_read_s ##1 access_s |-> prdata == {24'h0, $past(count_low_ff)})
        else $error("Low count read wrong");

    // Read data stands until the next read setup, so a slow master still sees it
    AST_PRDATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("Read data changed outside a read setup");

    AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        access && !mapped |-> pslverr && pready)
        else $error("Unmapped access not flagged");

    AST_MAPPED_OK: assert property (@(posedge pclk) disable iff (!presetn)
        access && mapped |-> !pslverr && pready)
        else $error("Mapped access flagged as error");

    // ****************************************
    // Checks: offset handed to the clock generator
    // ****************************************
    // The applied word trails the register write by one extra edge
    AST_ENABLE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        ctrl_write_s |=> ##1
        applied_offset.enable == $past(pwdata[OPO_ENABLE_BIT], 2))
        else $error("Enable not applied");

    AST_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        ctrl_write_s and pwdata[OPO_ENABLE_BIT] |=> ##1
        applied_offset.count[10:8] == $past(pwdata[2:0], 2))
        else $error("High offset bits wrong");

    // Low byte lands only while the enable already stands in the register
    AST_LOW_APPLIED: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
        low_write_s ##1 enable |=>
        applied_offset.count[7:0] == $past(pwdata[7:0], 2))
        else $error("Low offset bits not applied");

    AST_STEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        applied_offset.enable |->
        applied_shift_cycles == 16'(applied_offset.count) * 16'(OPO_STEP_CYCLES))
        else $error("Step scaling wrong");

    AST_DISABLED: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        !applied_offset.enable |->
        applied_offset.count == 11'h000 && applied_shift_cycles == 16'h0000)
        else $error("Shift applied while disabled");

    // Clearing the enable must drop the shift two edges later, not wait for the low byte
    AST_DISABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        ctrl_write_s and !pwdata[OPO_ENABLE_BIT] |=> ##1
        applied_offset == '0 && applied_shift_cycles == 16'h0000)
        else $error("Disable write did not clear the shift");

endmodule

// ---- dv/tb_output_phase_offset_regs.sv ----
// Self-checking testbench for the phase offset register slice
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module tb_output_phase_offset_regs import opo_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    opo_offset_type applied_offset;
    logic [15:0] applied_shift_cycles;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int n_compared = 0;

    opo_regs opo_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .applied_offset(applied_offset),
        .applied_shift_cycles(applied_shift_cycles));

    initial begin
        forever #2 pclk = ~pclk;
    end

    // ****************************************
    // APB master: holds the request until pready is seen high
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fails++;
            $display("ERROR %0t: no ready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        `CHK(applied_offset, 12'h000)
        `CHK(applied_shift_cycles, 16'h0000)
        apb(1'b0, 12'h018, 8'h00);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, 12'h01C, 8'h00);
        `CHK(rd, 32'h0000_0000)
        $display("t_reset done");
    endtask

    // Writes of both halves with an idle cycle between them, then wait for the two-edge update
    task automatic t_apply(input logic [10:0] w);
        apb(1'b1, 12'h018, {5'b00001, w[10:8]});
        apb(1'b1, 12'h01C, w[7:0]);
        repeat (3) @(posedge pclk);
        `CHK(applied_offset, {1'b1, w})
        `CHK(applied_shift_cycles, 16'(w * OPO_STEP_CYCLES))
        apb(1'b0, 12'h018, 8'h00);
        `CHK(rd, {24'h000000, 5'b00001, w[10:8]})
        apb(1'b0, 12'h01C, 8'h00);
        `CHK(rd, {24'h000000, w[7:0]})
        $display("t_apply done");
    endtask

    task automatic t_disable();
        apb(1'b1, 12'h018, 8'h05);
        repeat (3) @(posedge pclk);
        `CHK(applied_offset, 12'h000)
        `CHK(applied_shift_cycles, 16'h0000)
        pstrb <= 4'h0;
        apb(1'b1, 12'h01C, 8'hFF);
        pstrb <= 4'hF;
        apb(1'b0, 12'h01C, 8'h00);
        `CHK(rd, 32'h0000_0001)
        $display("t_disable done");
    endtask

    // Revision ignores writes; an unmapped index answers with an error
    task automatic t_revision();
        apb(1'b1, 12'h03C, 8'h5A);
        apb(1'b0, 12'h03C, 8'h00);
        `CHK(rd, {24'h000000, OPO_REVISION_DEFAULT})
        `CHK(err, 1'b0)
        apb(1'b0, 12'h020, 8'h00);
        `CHK(err, 1'b1)
        $display("t_revision done");
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_apply(11'h5A5);
        t_apply(11'h7FF);
        t_apply(11'h001);
        t_disable();
        t_revision();
        summarize();
    end

    // Whole run needs under a hundred cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        summarize();
    end
endmodule
